// ---- rtl/ddrini_ctrl.v ----
// DDR3 reset, initialization and mode register controller with Wishbone slave
`include "ddrini_consts.vh"
module ddrini_ctrl #(
	parameter RST_PWR_CYC  = (`DDRINI_T_RST_PWR_US * 1000 + `DDRINI_CLK_NS - 1) / `DDRINI_CLK_NS,
	parameter CKE_WAIT_CYC = (`DDRINI_T_CKE_WAIT_US * 1000 + `DDRINI_CLK_NS - 1) / `DDRINI_CLK_NS,
	// Device timings in clocks, to be set per speed grade
	parameter TXS_CYC      = 24,
	parameter TMRD_CYC     = 4,
	parameter TMOD_CYC     = 12,
	parameter TDLLK_CYC    = 512,
	parameter TZQINIT_CYC  = 512,
	parameter CNT_W        = 16
) (
	// Clock and reset
	input  wire        clk_sys_i,
	input  wire        arst_n_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Memory pins
	output reg         mem_reset_n_o,
	output reg         mem_ck_en_o,
	output reg         mem_cke_o,
	output reg         mem_odt_o,
	output reg         mem_cs_n_o,
	output reg         mem_ras_n_o,
	output reg         mem_cas_n_o,
	output reg         mem_we_n_o,
	output reg  [2:0]  mem_ba_o,
	output reg  [15:0] mem_addr_o
);
	localparam RST_WARM_CYC = (`DDRINI_T_RST_WARM_NS + `DDRINI_CLK_NS - 1) / `DDRINI_CLK_NS;
	localparam LEAD_CYC     = (`DDRINI_T_CKE_LEAD_NS + `DDRINI_CLK_NS - 1) / `DDRINI_CLK_NS;
	localparam STAB_NS_CYC  = (`DDRINI_T_CLK_STAB_NS + `DDRINI_CLK_NS - 1) / `DDRINI_CLK_NS;
	localparam STAB_CYC     = STAB_NS_CYC > `DDRINI_MIN_CLK_CYC ? STAB_NS_CYC : `DDRINI_MIN_CLK_CYC;
	localparam TXPR_CYC     = TXS_CYC > `DDRINI_MIN_CLK_CYC ? TXS_CYC : `DDRINI_MIN_CLK_CYC;
	localparam TFIN_CYC     = TDLLK_CYC > TZQINIT_CYC ? TDLLK_CYC : TZQINIT_CYC;
	localparam MRS_GAP_CYC  = TMRD_CYC > 1 ? TMRD_CYC : 1;

	localparam [3:0] S_IDLE  = 4'h0;
	localparam [3:0] S_RST   = 4'h1;
	localparam [3:0] S_CKLO  = 4'h2;
	localparam [3:0] S_WAIT  = 4'h3;
	localparam [3:0] S_NOP   = 4'h4;
	localparam [3:0] S_TXPR  = 4'h5;
	localparam [3:0] S_MRS   = 4'h6;
	localparam [3:0] S_GAP   = 4'h7;
	localparam [3:0] S_ZQ    = 4'h8;
	localparam [3:0] S_FIN   = 4'h9;
	localparam [3:0] S_READY = 4'ha;
	localparam [3:0] S_MOD   = 4'hb;

	reg [3:0]       state_reg;
	reg [CNT_W-1:0] cnt_reg;
	reg [1:0]       mr_idx_reg;
	reg             warm_reg;
	reg             single_reg;
	reg             ready_reg;
	reg             odt_sel_reg;
	reg [2:0]       rw_ba_reg;
	reg             start_pend_reg;
	reg             rewr_pend_reg;
	reg [15:0]      mr0_reg;
	reg [15:0]      mr1_reg;
	reg [15:0]      mr2_reg;
	reg [15:0]      mr3_reg;

	wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr    = wb_req & wb_we_i;
	wire [1:0] wa = wb_adr_i[3:2];
	wire ctrl_wr  = wb_wr & (wa == `DDRINI_REG_CTRL) & wb_sel_i[0];
	wire cnt_zero = (cnt_reg == {CNT_W{1'b0}});

	// Mode register selected by step index, order MR2, MR3, MR1, MR0; by rw_ba_reg on a single rewrite
	reg [2:0]  seq_ba;
	reg [15:0] seq_addr;
	always @* begin
		case (mr_idx_reg)
			2'h0: begin
				seq_ba   = `DDRINI_BA_MR2;
				seq_addr = mr2_reg;
			end
			2'h1: begin
				seq_ba   = `DDRINI_BA_MR3;
				seq_addr = mr3_reg;
			end
			2'h2: begin
				seq_ba   = `DDRINI_BA_MR1;
				seq_addr = mr1_reg;
				seq_addr[`DDRINI_A_DLL_EN_BIT] = 1'b0;
			end
			default: begin
				seq_ba   = `DDRINI_BA_MR0;
				seq_addr = mr0_reg;
				seq_addr[`DDRINI_A_DLL_RST_BIT] = 1'b1;
			end
		endcase
		if (single_reg) begin
			seq_ba   = rw_ba_reg;
			seq_addr = (rw_ba_reg == `DDRINI_BA_MR0) ? mr0_reg :
			           (rw_ba_reg == `DDRINI_BA_MR1) ? mr1_reg :
			           (rw_ba_reg == `DDRINI_BA_MR2) ? mr2_reg : mr3_reg;
		end
	end

	task set_cmd;
		input [3:0] cmd;
		begin
			mem_cs_n_o  <= cmd[3];
			mem_ras_n_o <= cmd[2];
			mem_cas_n_o <= cmd[1];
			mem_we_n_o  <= cmd[0];
		end
	endtask

	// Wishbone slave: ack one cycle after request, dropped the next cycle
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wb_ack_o       <= 1'b0;
			wb_dat_o       <= 32'h0;
			mr0_reg        <= 16'h0;
			mr1_reg        <= 16'h0;
			mr2_reg        <= 16'h0;
			mr3_reg        <= 16'h0;
			odt_sel_reg    <= 1'b0;
			rw_ba_reg      <= 3'h0;
			start_pend_reg <= 1'b0;
			rewr_pend_reg  <= 1'b0;
			warm_reg       <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			// Kept through the hold so a restart requested from ready is not lost
			if (state_reg == S_CKLO)
				start_pend_reg <= 1'b0;
			if (state_reg == S_MRS && single_reg)
				rewr_pend_reg <= 1'b0;
			if (wb_req && !wb_we_i) begin
				case (wa)
					`DDRINI_REG_CTRL: wb_dat_o <= {28'h0, odt_sel_reg, 1'b0, warm_reg, 1'b0};
					`DDRINI_REG_STAT: wb_dat_o <= {20'h0, rw_ba_reg, rewr_pend_reg, state_reg, 3'h0, ready_reg};
					`DDRINI_REG_MRA:  wb_dat_o <= {mr1_reg, mr0_reg};
					default:          wb_dat_o <= {mr3_reg, mr2_reg};
				endcase
			end
			if (ctrl_wr) begin
				warm_reg    <= wb_dat_i[`DDRINI_CTRL_WARM];
				odt_sel_reg <= wb_dat_i[`DDRINI_CTRL_ODT];
				if (wb_dat_i[`DDRINI_CTRL_START])
					start_pend_reg <= 1'b1;
				if (wb_dat_i[`DDRINI_CTRL_REWRITE] && ready_reg && !rewr_pend_reg) begin
					rewr_pend_reg <= 1'b1;
					rw_ba_reg     <= wb_dat_i[6:4];
				end
			end
			if (wb_wr && wa == `DDRINI_REG_MRA) begin
				if (wb_sel_i[0]) mr0_reg[7:0]  <= wb_dat_i[7:0];
				if (wb_sel_i[1]) mr0_reg[15:8] <= wb_dat_i[15:8];
				if (wb_sel_i[2]) mr1_reg[7:0]  <= wb_dat_i[23:16];
				if (wb_sel_i[3]) mr1_reg[15:8] <= wb_dat_i[31:24];
			end
			if (wb_wr && wa == `DDRINI_REG_MRB) begin
				if (wb_sel_i[0]) mr2_reg[7:0]  <= wb_dat_i[7:0];
				if (wb_sel_i[1]) mr2_reg[15:8] <= wb_dat_i[15:8];
				if (wb_sel_i[2]) mr3_reg[7:0]  <= wb_dat_i[23:16];
				if (wb_sel_i[3]) mr3_reg[15:8] <= wb_dat_i[31:24];
			end
		end
	end

	// Sequencer; reset pins assert from power-on until software starts
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg     <= S_RST;
			cnt_reg       <= RST_PWR_CYC[CNT_W-1:0];
			mr_idx_reg    <= 2'h0;
			single_reg    <= 1'b0;
			ready_reg     <= 1'b0;
			mem_reset_n_o <= 1'b0;
			mem_ck_en_o   <= 1'b0;
			mem_cke_o     <= 1'b0;
			mem_odt_o     <= 1'b0;
			mem_cs_n_o    <= 1'b1;
			mem_ras_n_o   <= 1'b1;
			mem_cas_n_o   <= 1'b1;
			mem_we_n_o    <= 1'b1;
			mem_ba_o      <= 3'h0;
			mem_addr_o    <= 16'h0;
		end else begin
			if (!cnt_zero)
				cnt_reg <= cnt_reg - 1'b1;
			case (state_reg)
				S_RST: begin
					// Full count loaded at power-on or cold restart; warm request reloads the shorter hold
					mem_reset_n_o <= 1'b0;
					mem_cke_o     <= 1'b0;
					mem_ck_en_o   <= 1'b0;
					ready_reg     <= 1'b0;
					set_cmd(`DDRINI_CMD_DES);
					if (cnt_zero && start_pend_reg) begin
						state_reg <= S_CKLO;
						cnt_reg   <= LEAD_CYC[CNT_W-1:0];
					end
				end
				S_CKLO: begin
					// CKE has been low the lead time already; release reset
					if (cnt_zero) begin
						mem_reset_n_o <= 1'b1;
						cnt_reg       <= CKE_WAIT_CYC[CNT_W-1:0];
						state_reg     <= S_WAIT;
					end
				end
				S_WAIT: begin
					// Clock started early enough to cover the stability window
					if (cnt_reg == STAB_CYC[CNT_W-1:0] + 1'b1)
						mem_ck_en_o <= 1'b1;
					if (cnt_zero) begin
						set_cmd(`DDRINI_CMD_NOP);
						state_reg <= S_NOP;
					end
				end
				S_NOP: begin
					mem_cke_o <= 1'b1;
					mem_odt_o <= odt_sel_reg;
					cnt_reg   <= TXPR_CYC[CNT_W-1:0];
					state_reg <= S_TXPR;
				end
				S_TXPR: begin
					if (cnt_zero) begin
						mr_idx_reg <= 2'h0;
						single_reg <= 1'b0;
						state_reg  <= S_MRS;
					end
				end
				S_MRS: begin
					set_cmd(`DDRINI_CMD_MRS);
					mem_ba_o   <= seq_ba;
					mem_addr_o <= seq_addr;
					cnt_reg    <= MRS_GAP_CYC[CNT_W-1:0] - 1'b1;
					state_reg  <= (single_reg || mr_idx_reg == 2'h3) ? S_MOD : S_GAP;
					if (single_reg || mr_idx_reg == 2'h3)
						cnt_reg <= TMOD_CYC[CNT_W-1:0] - 1'b1;
				end
				S_GAP: begin
					set_cmd(`DDRINI_CMD_NOP);
					if (cnt_zero) begin
						mr_idx_reg <= mr_idx_reg + 1'b1;
						state_reg  <= S_MRS;
					end
				end
				S_MOD: begin
					set_cmd(`DDRINI_CMD_NOP);
					if (cnt_zero)
						state_reg <= single_reg ? S_READY : S_ZQ;
				end
				S_ZQ: begin
					set_cmd(`DDRINI_CMD_ZQCL);
					mem_ba_o   <= 3'h0;
					mem_addr_o <= 16'h0;
					mem_addr_o[`DDRINI_A_ZQ_LONG_BIT] <= 1'b1;
					cnt_reg    <= TFIN_CYC[CNT_W-1:0] - 1'b1;
					state_reg  <= S_FIN;
				end
				S_FIN: begin
					set_cmd(`DDRINI_CMD_NOP);
					if (cnt_zero) begin
						ready_reg <= 1'b1;
						state_reg <= S_READY;
					end
				end
				S_READY: begin
					// No traffic is issued here, so the device is idle
					// Active, Read and Write are left to the controller that takes over
					set_cmd(`DDRINI_CMD_DES);
					single_reg <= 1'b0;
					if (start_pend_reg) begin
						mem_reset_n_o <= 1'b0;
						mem_cke_o     <= 1'b0;
						cnt_reg       <= warm_reg ? RST_WARM_CYC[CNT_W-1:0] : RST_PWR_CYC[CNT_W-1:0];
						state_reg     <= S_RST;
					end else if (rewr_pend_reg) begin
						single_reg <= 1'b1;
						state_reg  <= S_MRS;
					end
				end
				default: state_reg <= S_RST;
			endcase
		end
	end
endmodule

// ---- shared/ddrini_consts.vh ----
// Constants for the DDR3 initialization controller
// Functional notes
// - Access starts with Active: bank pins pick bank, address pins pick row.
// - Read or Write carries start column; A10 auto precharge, A12 chop select.
// - Hold reset low at least 200us after power is stable.
// - Drive CKE low at least 10ns before releasing reset.
// - Wait 500us after reset release before raising CKE.
// - Clock runs stable for max of 10ns and five clocks before CKE rises.
// - Present NOP or Deselect before the cycle CKE goes high.
// - Keep CKE high continuously until initialization completes.
// - Hold ODT static low from CKE high until initialization ends; code drives ODT from the CTRL ODT bit as CKE rises.
// - Wait tXPR, max of tXS and five clocks, before first mode register write.
// - Load MR2, MR3, MR1, MR0 in order, then long ZQ calibration.
// - Bank pins select register: MR0 000, MR1 001, MR2 010, MR3 011.
// - MR1 write drives A0 low; MR0 write drives A8 high for DLL reset.
// - Warm reset: reset low at least 100ns, CKE low first, repeat from 500us.
// - All four mode registers written fully after every reset; rewrites allowed later.
// - Each mode register write drives every address field with intended values.
// - Space consecutive mode register writes by at least tMRD.
// - Wait tMOD after a mode register write before any other command.
// - Rewrite mode registers only when idle with CKE high.
// - Mode register write encodes CS, RAS, CAS, WE all low.
`ifndef DDRINI_CONSTS_VH
`define DDRINI_CONSTS_VH
`define DDRINI_CLK_NS        25
`define DDRINI_T_RST_PWR_US  200
`define DDRINI_T_RST_WARM_NS 100
`define DDRINI_T_CKE_LEAD_NS 10
`define DDRINI_T_CKE_WAIT_US 500
`define DDRINI_T_CLK_STAB_NS 10
`define DDRINI_MIN_CLK_CYC   5
`define DDRINI_W_CMD         4
// Command encodings {cs_n, ras_n, cas_n, we_n}
`define DDRINI_CMD_NOP       4'h7
`define DDRINI_CMD_DES       4'hf
`define DDRINI_CMD_MRS       4'h0
`define DDRINI_CMD_ZQCL      4'h6
// Bank codes for mode registers
`define DDRINI_BA_MR0        3'h0
`define DDRINI_BA_MR1        3'h1
`define DDRINI_BA_MR2        3'h2
`define DDRINI_BA_MR3        3'h3
`define DDRINI_A_DLL_EN_BIT  0
`define DDRINI_A_DLL_RST_BIT 8
`define DDRINI_A_ZQ_LONG_BIT 10
// Wishbone register word addresses (byte address bits 3:2)
`define DDRINI_REG_CTRL      2'h0
`define DDRINI_REG_STAT      2'h1
`define DDRINI_REG_MRA       2'h2
`define DDRINI_REG_MRB       2'h3
// Control bits
`define DDRINI_CTRL_START    0
`define DDRINI_CTRL_WARM     1
`define DDRINI_CTRL_REWRITE  2
`define DDRINI_CTRL_ODT      3
`endif

// ---- tb/ddrini_ctrl_monitor.sv ----
// Concurrent checks on the DDR3 initialization controller ports
`include "ddrini_consts.vh"
module ddrini_ctrl_monitor #(
	parameter CKE_WAIT_CYC = 20,
	parameter TXS_CYC      = 24,
	parameter TMRD_CYC     = 4,
	parameter TMOD_CYC     = 12
) (
	input wire        clk_sys_i,
	input wire        arst_n_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_ack_o,
	input wire        mem_reset_n_o,
	input wire        mem_ck_en_o,
	input wire        mem_cke_o,
	input wire        mem_odt_o,
	input wire        mem_cs_n_o,
	input wire        mem_ras_n_o,
	input wire        mem_cas_n_o,
	input wire        mem_we_n_o,
	input wire [2:0]  mem_ba_o,
	input wire [15:0] mem_addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TXPR = TXS_CYC > 5 ? TXS_CYC : 5;
	wire [3:0] cmd = {mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o};
	wire       mrs = mem_cke_o && cmd == `DDRINI_CMD_MRS;
	logic [15:0] lo_cnt, hi_cnt, cke_cnt, mrs_cnt;
	logic [2:0]  idx;
	// cke_cnt and mrs_cnt saturate so long idle stretches never wrap into a false failure
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lo_cnt <= 16'h0;
			hi_cnt <= 16'h0;
			cke_cnt <= 16'h0;
			mrs_cnt <= 16'hffff;
			idx <= 3'h0;
		end else begin
			lo_cnt <= mem_reset_n_o ? 16'h0 : lo_cnt + 16'h1;
			hi_cnt <= (mem_reset_n_o && !mem_cke_o) ? hi_cnt + 16'h1 : 16'h0;
			cke_cnt <= mem_cke_o ? cke_cnt + {15'h0, cke_cnt != 16'hffff} : 16'h0;
			mrs_cnt <= mrs ? 16'h1 : mrs_cnt + {15'h0, mrs_cnt != 16'hffff};
			idx <= !mem_reset_n_o ? 3'h0 : idx + {2'h0, mrs && idx < 3'h4};
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	a_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse one cycle after request");
	a_cke_lead_low: assert property ($rose(mem_reset_n_o) |-> !mem_cke_o && $past(!mem_cke_o))
		else $error("cke not low before reset release");
	a_reset_hold_min: assert property ($rose(mem_reset_n_o) |-> lo_cnt >= 16'd4)
		else $error("reset held too briefly");
	a_cke_wait_min: assert property ($rose(mem_cke_o) |-> hi_cnt >= CKE_WAIT_CYC)
		else $error("cke raised too soon after reset release");
	a_clock_stable: assert property ($rose(mem_cke_o) |-> mem_ck_en_o && $past(mem_ck_en_o, 5))
		else $error("clock not running long enough before cke");
	a_nop_before_cke: assert property ($rose(mem_cke_o) |-> $past(cmd) inside {`DDRINI_CMD_NOP, `DDRINI_CMD_DES})
		else $error("no nop or deselect before cke");
	a_odt_static: assert property (mem_cke_o && $past(mem_cke_o) |-> $stable(mem_odt_o) && !mem_odt_o)
		else $error("odt moved during initialization");
	a_txpr_wait: assert property (mrs && idx == 3'h0 |-> cke_cnt >= TXPR)
		else $error("first mode write before txpr");
	a_mr_order: assert property (mrs && idx < 3'h4 |-> mem_ba_o == {1'b0, ~idx[1], idx[0] ^ idx[1]})
		else $error("mode register order wrong");
	a_dll_bits: assert property (mrs && idx < 3'h4 |-> (mem_ba_o != 3'h1 || !mem_addr_o[0])
		&& (mem_ba_o != 3'h0 || mem_addr_o[8]))
		else $error("dll enable or reset bit wrong");
	a_mrd_spacing: assert property (mrs |-> mrs_cnt >= TMRD_CYC)
		else $error("mode writes too close");
	a_mod_wait: assert property (mem_cke_o && !(cmd inside {`DDRINI_CMD_NOP, `DDRINI_CMD_DES, `DDRINI_CMD_MRS})
		|-> mrs_cnt >= TMOD_CYC)
		else $error("command too soon after mode write");
	a_zq_last: assert property (mem_cke_o && cmd == `DDRINI_CMD_ZQCL |-> idx == 3'h4 && mem_addr_o[10])
		else $error("long calibration misplaced");
	c_cke_rise: cover property ($rose(mem_cke_o));
	c_mr0_write: cover property (mrs && idx == 3'h3);
	c_rewrite: cover property (mrs && idx == 3'h4);
endmodule
bind ddrini_ctrl ddrini_ctrl_monitor #(.CKE_WAIT_CYC(CKE_WAIT_CYC), .TXS_CYC(TXS_CYC), .TMRD_CYC(TMRD_CYC),
	.TMOD_CYC(TMOD_CYC)) mon_u (.*);

// ---- tb/ddrini_ctrl_tb_top.sv ----
// Self-checking bench for the DDR3 initialization controller
`include "ddrini_consts.vh"
module ddrini_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0, arst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0, rdat, q;
	logic ack, rst_n, ck_en, cke, odt, cs_n, ras_n, cas_n, we_n, term_on;
	logic [2:0] ba;
	logic [15:0] addr, mr [4];
	logic [7:0] mrs_n, zq_n;
	int error_cnt = 0, check_count = 0;
	initial forever #12.5 clk_sys_i = ~clk_sys_i;
	ddrini_ctrl #(.RST_PWR_CYC(20), .CKE_WAIT_CYC(20), .TDLLK_CYC(16), .TZQINIT_CYC(16)) dut_u (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.mem_reset_n_o(rst_n), .mem_ck_en_o(ck_en), .mem_cke_o(cke), .mem_odt_o(odt), .mem_cs_n_o(cs_n),
		.mem_ras_n_o(ras_n), .mem_cas_n_o(cas_n), .mem_we_n_o(we_n), .mem_ba_o(ba), .mem_addr_o(addr));
	ddrini_mem_model mem_u (.clk_i(clk_sys_i), .ck_run_i(ck_en), .reset_n_i(rst_n), .cke_i(cke),
		.cmd_i({cs_n, ras_n, cas_n, we_n}), .ba_i(ba), .addr_i(addr), .mr_o(mr), .mrs_cnt_o(mrs_n),
		.zq_cnt_o(zq_n), .term_on_o(term_on));
	task results();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single cycle; ack is read as sampled at the edge, before that edge's updates land
	task wb_rw(input logic w, input logic [1:0] r, input logic [31:0] d, output logic [31:0] rd);
		int n;
		@(posedge clk_sys_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {r, 2'b00};
		dat <= d;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			results();
		end
	endtask
	task wait_stat(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			wb_rw(1'b0, `DDRINI_REG_STAT, 32'h0, q);
			n++;
		end while ((q & m) !== v && n < 3000);
		chk(q & m, v);
		if (n >= 3000)
			results();
	endtask
	task chk_mrs(input logic [63:0] exp, input logic [7:0] cnt, input logic [7:0] zq);
		chk({mr[3], mr[2]}, exp[63:32]);
		chk({mr[1], mr[0]}, exp[31:0]);
		chk({16'h0, mrs_n, zq_n}, {16'h0, cnt, zq});
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		// Power-up hold is counted by the controller; START waits for it
		repeat (30) @(posedge clk_sys_i);
		wb_rw(1'b0, `DDRINI_REG_STAT, 32'h0, q);
		chk(q & 32'h1, 32'h0);
		wb_rw(1'b1, `DDRINI_REG_MRA, 32'h0045_0a30, q);
		wb_rw(1'b1, `DDRINI_REG_MRB, 32'h0004_0018, q);
		wb_rw(1'b0, `DDRINI_REG_MRA, 32'h0, q);
		chk(q, 32'h0045_0a30);
		wb_rw(1'b0, `DDRINI_REG_MRB, 32'h0, q);
		chk(q, 32'h0004_0018);
		$display("test registers done");
		wb_rw(1'b1, `DDRINI_REG_CTRL, 32'h1, q);
		wait_stat(32'h1, 32'h1);
		chk_mrs(64'h0004_0018_0044_0b30, 8'h4, 8'h1);
		chk({31'h0, term_on}, 32'h1);
		$display("test power-up done");
		wb_rw(1'b1, `DDRINI_REG_MRB, 32'h0000_0010, q);
		wb_rw(1'b1, `DDRINI_REG_CTRL, 32'h3, q);
		wait_stat(32'h1, 32'h0);
		wait_stat(32'h1, 32'h1);
		chk_mrs(64'h0000_0010_0044_0b30, 8'h8, 8'h2);
		wb_rw(1'b0, `DDRINI_REG_CTRL, 32'h0, q);
		chk(q, 32'h2);
		$display("test warm reset done");
		wb_rw(1'b1, `DDRINI_REG_MRB, 32'h0000_0028, q);
		wb_rw(1'b1, `DDRINI_REG_CTRL, 32'h24, q);
		wait_stat(32'h100, 32'h0);
		repeat (20) @(posedge clk_sys_i);
		chk_mrs(64'h0000_0028_0044_0b30, 8'h9, 8'h2);
		$display("test rewrite done");
		results();
	end
endmodule

// ---- tb/ddrini_mem_model.sv ----
// Behavioural DDR3 device that records mode register writes seen on its pins
`include "ddrini_consts.vh"
module ddrini_mem_model (
	// Clock and reset
	input  wire         clk_i,
	input  wire         ck_run_i,
	input  wire         reset_n_i,
	// Command pins
	input  wire         cke_i,
	input  wire  [3:0]  cmd_i,
	input  wire  [2:0]  ba_i,
	input  wire  [15:0] addr_i,
	// Observed state
	output logic [15:0] mr_o [4],
	output logic [7:0]  mrs_cnt_o = 8'h0,
	output logic [7:0]  zq_cnt_o = 8'h0,
	output logic        term_on_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cke_reg;
	// Device only sees edges while the clock pair runs
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cke_reg <= 1'b0;
			term_on_o <= 1'b0;
			for (int i = 0; i < 4; i++)
				mr_o[i] <= 16'hxxxx;
		end else if (ck_run_i) begin
			cke_reg <= cke_i;
			if (cke_i)
				term_on_o <= 1'b1;
			// Mode writes touch no array state, so none is modelled
			// Array bursts and their row and column decode are not modelled
			if (cke_i && cke_reg && cmd_i == `DDRINI_CMD_MRS) begin
				mr_o[ba_i[1:0]] <= addr_i;
				mrs_cnt_o <= mrs_cnt_o + 8'h1;
			end
			if (cke_i && cke_reg && cmd_i == `DDRINI_CMD_ZQCL)
				zq_cnt_o <= zq_cnt_o + 8'h1;
		end
	end
endmodule
